//--- ioc_pkg.sv
/*
   Constants, states and pin bundles for the option end of the I/O channel.
   Assumes every channel signal is synchronous to the rising edge of i_clk.

*/
package ioc_pkg;
   localparam int AD_W       = 32;
   localparam int IO_ADDR_W  = 27;
   localparam int WORD_LSB   = 2;
   localparam int MEM_DEPTH  = 16;
   localparam int TIMEOUT_NS = 10000;
   localparam logic [AD_W-1:0] AD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      IO_IDLE   = 2'b00,
      IO_ACCESS = 2'b01,
      IO_RESP   = 2'b10,
      IO_GAP    = 2'b11
   } ioc_io_state_t;

   typedef enum logic [2:0] {
      DM_IDLE  = 3'b000,
      DM_ASK   = 3'b001,
      DM_WDATA = 3'b010,
      DM_RDATA = 3'b011,
      DM_DONE  = 3'b100
   } ioc_dma_state_t;

   // Channel lines driven by the system
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic            sel_n;
      logic            write_n;
      logic            dma_grant_strobe_n;
      logic            dma_fault_n;
   } ioc_sys_pins_t;

   // Channel lines driven by the option
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic            ad_oe;
      logic            io_done_n;
      logic            io_clash_n;
      logic            dma_fetch_ask_n;
      logic            dma_store_ask_n;
      logic            option_irq_line_n;
   } ioc_opt_pins_t;

   // DMA request from the option's own logic
   typedef struct packed {
      logic            valid;
      logic            write;
      logic [AD_W-1:0] addr;
      logic [AD_W-1:0] wdata;
   } ioc_dma_req_t;
endpackage : ioc_pkg

//--- ioc_mem.sv
/*
   Small option register memory with registered read data.
   Assumes one clock and a single writer.
*/
`timescale 1ns/1ps
module ioc_mem #(
   parameter int W     = 32,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock
   input  wire logic          i_clk,
   // Write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [W-1:0]  i_wdata,
   // Read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [W-1:0]  o_rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule : ioc_mem

//--- ioc_option_if.sv
/*
   Option end of the channel: I/O slave with clash answer, DMA requester,
   level interrupt line.
   Assumes the system obeys its own timing and drives ad outside option drive.
*/
`timescale 1ns/1ps
module ioc_option_if #(
   parameter int DEPTH = ioc_pkg::MEM_DEPTH
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // Channel
   input  wire ioc_pkg::ioc_sys_pins_t i_sys,
   output ioc_pkg::ioc_opt_pins_t      o_opt,
   // DMA user side
   input  wire ioc_pkg::ioc_dma_req_t  i_dma,
   output logic                        o_dma_ready,
   output logic                        o_dma_done,
   output logic                        o_dma_fault,
   output logic [ioc_pkg::AD_W-1:0]    o_dma_rdata,
   // Interrupt user side
   input  wire logic                   i_irq_event,
   input  wire logic                   i_irq_clear
);
   import ioc_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [IO_ADDR_W-WORD_LSB-1:0] DEPTH_W = (IO_ADDR_W-WORD_LSB)'(DEPTH);

   ioc_io_state_t          io_state,   next_io_state;
   ioc_dma_state_t         dma_state,  next_dma_state;
   ioc_opt_pins_t          opt,        next_opt;
   logic [IO_ADDR_W-1:0]   io_addr,    next_io_addr;
   logic                   io_wr,      next_io_wr;
   logic                   clash,      next_clash;
   logic                   dma_wr,     next_dma_wr;
   logic [AD_W-1:0]        dma_wdata,  next_dma_wdata;
   logic [AD_W-1:0]        dma_rdata,  next_dma_rdata;
   logic                   fault_acc,  next_fault_acc;
   logic                   irq,        next_irq;
   logic                   mem_we;
   logic [AW-1:0]          mem_raddr;
   logic [AD_W-1:0]        mem_rdata;

   function automatic logic word_hit(input logic [IO_ADDR_W-1:0] a);
      return a[IO_ADDR_W-1:WORD_LSB] < DEPTH_W;
   endfunction : word_hit

   function automatic logic [AW-1:0] word_idx(input logic [IO_ADDR_W-1:0] a);
      return a[WORD_LSB +: AW];
   endfunction : word_idx

   ioc_mem #(
      .W     (AD_W),
      .DEPTH (DEPTH)
   ) u_mem (
      .i_clk   (i_clk),
      .i_we    (mem_we),
      .i_waddr (word_idx(io_addr)),
      .i_wdata (i_sys.ad),
      .i_raddr (mem_raddr),
      .o_rdata (mem_rdata)
   );

   assign o_opt       = opt;
   assign o_dma_ready = (dma_state == DM_IDLE) && (io_state == IO_IDLE) && i_sys.sel_n;
   assign o_dma_done  = (dma_state == DM_DONE);
   assign o_dma_fault = fault_acc;
   assign o_dma_rdata = dma_rdata;
   assign mem_raddr   = word_idx(i_sys.ad[IO_ADDR_W-1:0]);
   assign mem_we      = (io_state == IO_ACCESS) && io_wr && !clash && word_hit(io_addr);

   // Channel next state
   always_comb begin
      next_io_state            = io_state;
      next_dma_state           = dma_state;
      next_io_addr             = io_addr;
      next_io_wr               = io_wr;
      next_clash               = clash;
      next_dma_wr              = dma_wr;
      next_dma_wdata           = dma_wdata;
      next_dma_rdata           = dma_rdata;
      next_fault_acc           = fault_acc;
      next_opt                 = opt;
      next_opt.io_done_n       = 1'b1;
      next_opt.io_clash_n      = 1'b1;
      next_opt.option_irq_line_n = !next_irq;
      unique case (io_state)
         IO_IDLE: begin
            if (!i_sys.sel_n) begin
               next_io_addr  = i_sys.ad[IO_ADDR_W-1:0];
               next_io_wr    = !i_sys.write_n;
               next_clash    = (dma_state != DM_IDLE);
               next_io_state = IO_ACCESS;
            end
         end
         IO_ACCESS: begin
            next_opt.io_done_n  = 1'b0;
            next_opt.io_clash_n = !clash;
            if (!io_wr && !clash) begin
               next_opt.ad    = word_hit(io_addr) ? mem_rdata : AD_ZERO;
               next_opt.ad_oe = 1'b1;
            end
            next_io_state = IO_RESP;
         end
         IO_RESP: begin
            if (!clash) begin
               next_opt.ad_oe = 1'b0; // Leave a waiting DMA address driven
            end
            next_io_state  = IO_GAP;
         end
         IO_GAP: begin
            if (i_sys.sel_n) begin
               next_io_state = IO_IDLE;
            end
         end
      endcase
      unique case (dma_state)
         DM_IDLE: begin
            if (i_dma.valid && o_dma_ready) begin
               next_dma_wr     = i_dma.write;
               next_dma_wdata  = i_dma.wdata;
               next_fault_acc  = 1'b0;
               next_opt.ad     = i_dma.addr;
               next_opt.ad_oe  = 1'b1;
               next_opt.dma_store_ask_n = !i_dma.write;
               next_opt.dma_fetch_ask_n = i_dma.write;
               next_dma_state  = DM_ASK;
            end
         end
         DM_ASK: begin
            if (!i_sys.dma_grant_strobe_n) begin
               next_opt.dma_fetch_ask_n = 1'b1;
               next_opt.dma_store_ask_n = 1'b1;
               next_fault_acc = !i_sys.dma_fault_n;
               next_opt.ad    = dma_wdata;
               next_opt.ad_oe = dma_wr;
               next_dma_state = dma_wr ? DM_WDATA : DM_RDATA;
            end
         end
         DM_WDATA: begin
            next_opt.ad_oe = 1'b0;
            if (!i_sys.dma_grant_strobe_n && !i_sys.dma_fault_n) begin
               next_fault_acc = 1'b1;
            end
            next_dma_state = DM_DONE;
         end
         DM_RDATA: begin
            if (!i_sys.dma_grant_strobe_n) begin
               next_dma_rdata = i_sys.ad;
               next_fault_acc = fault_acc || !i_sys.dma_fault_n;
               next_dma_state = DM_DONE;
            end
         end
         DM_DONE: begin
            next_dma_state = DM_IDLE;
         end
         default: begin
            next_dma_state = DM_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         io_state  <= IO_IDLE;
         dma_state <= DM_IDLE;
         io_addr   <= '0;
         io_wr     <= 1'b0;
         clash     <= 1'b0;
         dma_wr    <= 1'b0;
         dma_wdata <= AD_ZERO;
         dma_rdata <= AD_ZERO;
         fault_acc <= 1'b0;
         opt       <= '{ad: AD_ZERO, ad_oe: 1'b0, default: 1'b1};
      end else begin
         io_state  <= next_io_state;
         dma_state <= next_dma_state;
         io_addr   <= next_io_addr;
         io_wr     <= next_io_wr;
         clash     <= next_clash;
         dma_wr    <= next_dma_wr;
         dma_wdata <= next_dma_wdata;
         dma_rdata <= next_dma_rdata;
         fault_acc <= next_fault_acc;
         opt       <= next_opt;
      end
   end

   // Interrupt holding; set wins over clear
   always_comb begin
      next_irq = i_irq_event || (irq && !i_irq_clear);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // Checks
   property p_ask_hold;
      @(posedge i_clk) disable iff (i_rst)
      (!opt.dma_fetch_ask_n || !opt.dma_store_ask_n) && i_sys.dma_grant_strobe_n
      |=> (!opt.dma_fetch_ask_n || !opt.dma_store_ask_n);
   endproperty
   a_ask_hold: assert property (p_ask_hold) else $error("DMA ask dropped before grant");

   property p_ask_release;
      @(posedge i_clk) disable iff (i_rst)
      (dma_state == DM_ASK) && !i_sys.dma_grant_strobe_n
      |=> opt.dma_fetch_ask_n && opt.dma_store_ask_n ##1 dma_state == DM_DONE
          ##1 dma_state == DM_IDLE || $past(dma_state) == DM_RDATA;
   endproperty
   a_ask_release: assert property (p_ask_release) else $error("DMA ask not released");

   property p_irq_hold;
      @(posedge i_clk) disable iff (i_rst)
      !opt.option_irq_line_n && !i_irq_clear |=> !opt.option_irq_line_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("Interrupt dropped early");

   property p_irq_level;
      @(posedge i_clk) disable iff (i_rst)
      i_irq_event ##1 !i_irq_clear |=> !opt.option_irq_line_n;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("Interrupt level missing");

   property p_fault_gate;
      @(posedge i_clk) disable iff (i_rst)
      (dma_state inside {DM_WDATA, DM_RDATA}) && i_sys.dma_grant_strobe_n
      |=> fault_acc == $past(fault_acc);
   endproperty
   a_fault_gate: assert property (p_fault_gate) else $error("Fault taken without grant");

   property p_addr_decode;
      @(posedge i_clk) disable iff (i_rst)
      (io_state == IO_IDLE) && !i_sys.sel_n
      |=> io_addr == $past(i_sys.ad[IO_ADDR_W-1:0]) ##1 !opt.io_done_n;
   endproperty
   a_addr_decode: assert property (p_addr_decode) else $error("Address not captured");

   property p_clash_recover;
      @(posedge i_clk) disable iff (i_rst)
      !opt.io_clash_n ##1 i_sys.sel_n |=> io_state == IO_IDLE;
   endproperty
   a_clash_recover: assert property (p_clash_recover) else $error("No recovery after clash");

   property p_clash_with_done;
      @(posedge i_clk) disable iff (i_rst)
      !opt.io_clash_n |-> !opt.io_done_n && $past(io_state, 2) == IO_IDLE
                          && !$past(i_sys.sel_n, 2);
   endproperty
   a_clash_with_done: assert property (p_clash_with_done) else $error("Clash misplaced");

   property p_gap_wait;
      @(posedge i_clk) disable iff (i_rst)
      (io_state == IO_GAP) && !i_sys.sel_n |=> io_state == IO_GAP;
   endproperty
   a_gap_wait: assert property (p_gap_wait) else $error("Reselect without idle");

   c_io_read:  cover property (@(posedge i_clk) !opt.io_done_n && opt.ad_oe);
   c_io_clash: cover property (@(posedge i_clk) !opt.io_clash_n);
   c_dma_done: cover property (@(posedge i_clk) o_dma_done && !dma_wr);
   c_dma_err:  cover property (@(posedge i_clk) o_dma_done && o_dma_fault);
endmodule : ioc_option_if

//--- ioc_sys_model.sv
/*
   System-end partner model: grants DMA after a set delay and runs I/O cycles.
   Assumes the bench sets i_wait and i_fault and calls io() for I/O traffic.
*/
`timescale 1ns/1ps
module ioc_sys_model (
   // Clock
   input  wire logic                   i_clk,
   // Bench controls
   input  wire logic [3:0]             i_wait,
   input  wire logic [1:0]             i_fault,
   // Channel
   input  wire ioc_pkg::ioc_opt_pins_t i_opt,
   output ioc_pkg::ioc_sys_pins_t      o_sys
);
   import ioc_pkg::*;
   logic [AD_W-1:0] drv = AD_ZERO, got, adr;
   logic            sel_n = 1'b1, wr_n = 1'b1, gnt_n = 1'b1, busy = 1'b0, dma = 1'b0, rd;
   int              n;
   // Wire level; i_fault[1] is fault noise outside the grant
   assign o_sys = '{ad: i_opt.ad_oe ? i_opt.ad : drv, sel_n: sel_n, write_n: wr_n,
                    dma_grant_strobe_n: gnt_n,
                    dma_fault_n: !(gnt_n ? i_fault[1] : i_fault[0])};
   // Idle bus value flips every cycle
   always @(posedge i_clk) #1 if (!busy && !dma) drv = ~drv;
   // DMA grant; a read gets its word in the cycle after the grant
   always @(posedge i_clk) begin
      if (!dma && !(i_opt.dma_fetch_ask_n && i_opt.dma_store_ask_n)) begin
         dma = 1'b1;
         rd  = !i_opt.dma_fetch_ask_n;
         repeat (i_wait) @(posedge i_clk);
         #1 gnt_n = 1'b0;
         @(posedge i_clk);
         adr = o_sys.ad;
         got = adr;
         #1 gnt_n = !rd;
         if (rd) drv = got ^ 32'hA5A5_5A5A;
         @(posedge i_clk);
         if (!rd) got = o_sys.ad;
         #1 gnt_n = 1'b1;
         repeat (2) @(posedge i_clk);
         dma = 1'b0;
      end
   end
   // One I/O cycle; gives up only after the full timeout
   task automatic io(input logic w, input logic [AD_W-1:0] a, d,
                     output logic [AD_W-1:0] q, output logic clash);
      @(posedge i_clk);
      #1 busy = 1'b1;
      sel_n = 1'b0;
      wr_n  = !w;
      drv   = a;
      @(posedge i_clk);
      #1 if (w) drv = d;
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (i_opt.io_done_n && n < TIMEOUT_NS / 100);
      q     = o_sys.ad;
      clash = !i_opt.io_clash_n;
      @(posedge i_clk);
      #1 sel_n = 1'b1;
      busy  = 1'b0;
   endtask : io
endmodule : ioc_sys_model

//--- test_io_channel_option_interface.sv
/*
   Self-checking bench for the option end of the I/O channel.
   Assumes ioc_sys_model plays the system end.
*/
`timescale 1ns/1ps
module test_io_channel_option_interface;
   import ioc_pkg::*;
   logic            clk = 1'b0, rst = 1'b1, irq_set = 1'b0, irq_clr = 1'b0, pend = 1'b0;
   logic            cl, rdy, done, flt_o;
   logic [3:0]      wt = 4'h0;
   logic [1:0]      flt = 2'b00;
   logic [AD_W-1:0] rdata, q, a, d, mem [MEM_DEPTH];
   ioc_sys_pins_t   sys;
   ioc_opt_pins_t   opt;
   ioc_dma_req_t    req = '0;
   int              miscompares = 0, checks = 0, seed = 79, k, n;

   ioc_option_if #(.DEPTH(MEM_DEPTH)) ioc_option_if_inst (.i_clk(clk), .i_rst(rst),
      .i_sys(sys), .o_opt(opt), .i_dma(req), .o_dma_ready(rdy), .o_dma_done(done),
      .o_dma_fault(flt_o), .o_dma_rdata(rdata), .i_irq_event(irq_set),
      .i_irq_clear(irq_clr));
   ioc_sys_model ioc_sys_model_inst (.i_clk(clk), .i_wait(wt), .i_fault(flt),
      .i_opt(opt), .o_sys(sys));

   initial begin
      forever #50 clk = ~clk;
   end
   task automatic end_of_test;
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic cmp_word(input logic [AD_W-1:0] g, e, input string m);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : cmp_word
   task automatic cmp_flag(input logic g, e, input string m);
      cmp_word({31'h0, g}, {31'h0, e}, m);
   endtask : cmp_flag
   function automatic logic [AD_W-1:0] exp_io(input logic [AD_W-1:0] x);
      return (x[26:2] < MEM_DEPTH) ? mem[x[5:2]] : AD_ZERO;
   endfunction : exp_io
   // A request with no grant yet must still stand at the next edge
   always @(posedge clk) begin
      if (pend) cmp_flag(opt.dma_fetch_ask_n & opt.dma_store_ask_n, 1'b0, "ask");
      pend = !rst && !(opt.dma_fetch_ask_n & opt.dma_store_ask_n) && sys.dma_grant_strobe_n;
   end
   task automatic io_wr(input logic [AD_W-1:0] x, y);
      ioc_sys_model_inst.io(1'b1, x, y, q, cl);
      cmp_flag(cl, 1'b0, "wr clash");
      if (x[26:2] < MEM_DEPTH) mem[x[5:2]] = y;
   endtask : io_wr
   task automatic io_rd(input logic [AD_W-1:0] x);
      ioc_sys_model_inst.io(1'b0, x, AD_ZERO, q, cl);
      cmp_flag(cl, 1'b0, "rd clash");
      cmp_word(q, exp_io(x), "rd data");
   endtask : io_rd
   task automatic dma(input logic w, input logic [AD_W-1:0] x, y, input logic [3:0] t,
                      input logic [1:0] f);
      wt  = t;
      flt = f;
      for (n = 0; n < 50 && !rdy; n++) @(posedge clk) #1;
      req = '{valid: 1'b1, write: w, addr: x, wdata: y};
      @(posedge clk) #1 req.valid = 1'b0;
      cmp_flag(rdy, 1'b0, "dma busy");
      for (n = 0; n < 50 && !done; n++) @(posedge clk) #1;
      cmp_flag(done, 1'b1, "dma done");
      cmp_flag(flt_o, f[0], "dma fault");
      cmp_word(ioc_sys_model_inst.adr, x, "dma addr");
      cmp_word(w ? ioc_sys_model_inst.got : rdata, w ? y : x ^ 32'hA5A5_5A5A, "dma data");
      flt = 2'b00;
      @(posedge clk) #1;
      cmp_flag(rdy, 1'b1, "dma ready");
   endtask : dma

   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      for (k = 0; k < MEM_DEPTH; k++) io_wr({k[29:0], 2'b00}, $random(seed));
      io_wr(32'h0400_000C, 32'hDEAD_BEEF);
      io_rd(32'hF800_000C);
      io_rd(32'h0400_000C);
      for (k = 0; k < 60; k++) begin
         a = $random(seed) & 32'hFC00_003F;
         d = $random(seed);
         case ({$random(seed)} % 3)
            0: io_wr(a, d);
            1: io_rd(a);
            default: dma(a[5], d, ~d, {1'b0, a[2:0]}, a[4:3]);
         endcase
      end
      fork
         dma(1'b1, 32'h1234_5670, 32'h0BAD_F00D, 4'h6, 2'b00);
         begin
            repeat (2) @(posedge clk);
            ioc_sys_model_inst.io(1'b0, 32'h0000_0008, AD_ZERO, q, cl);
            cmp_flag(cl, 1'b1, "clash");
         end
      join
      io_wr(32'h0000_0010, 32'hC0DE_0001);
      io_rd(32'h0000_0008);
      irq_set = 1'b1;
      @(posedge clk) #1 irq_set = 1'b0;
      repeat (3) begin
         io_rd(32'h0000_0010);
         cmp_flag(opt.option_irq_line_n, 1'b0, "irq held");
      end
      irq_clr = 1'b1;
      @(posedge clk) #1 irq_clr = 1'b0;
      cmp_flag(opt.option_irq_line_n, 1'b1, "irq clear");
      {irq_set, irq_clr} = 2'b11;
      @(posedge clk) #1 {irq_set, irq_clr} = 2'b00;
      cmp_flag(opt.option_irq_line_n, 1'b0, "irq wins");
      end_of_test();
   end
   initial begin
      #3_000_000;
      miscompares++;
      end_of_test();
   end
endmodule : test_io_channel_option_interface
